/* File: hw/otflr_pkg.sv */
// Constants and types of the overtemperature fault limit and response block
package otflr_pkg;
    localparam logic [7:0]  CMD_OT_RESPONSE   = 8'h50;
    localparam logic [7:0]  CMD_OT_THRESHOLD  = 8'h4F;
    localparam logic [7:0]  CMD_STATUS_CML    = 8'h7E;
    localparam int          THR_EXP_MSB       = 15;
    localparam int          THR_EXP_LSB       = 11;
    localparam int          THR_RSV_MSB       = 10;
    localparam int          THR_RSV_LSB       = 6;
    localparam int          THR_MANT_MSB      = 5;
    localparam logic [4:0]  THR_EXPONENT      = 5'h02;
    localparam logic [5:0]  THR_MANT_DEFAULT  = 6'h22;
    localparam int          RSP_SHUTDOWN_BIT  = 7;
    localparam int          RSP_ZERO_BIT      = 6;
    localparam int          RSP_RETRY_MSB     = 5;
    localparam int          RSP_RETRY_LSB     = 3;
    localparam logic [2:0]  RETRY_LATCH       = 3'h0;
    localparam logic [2:0]  RETRY_AUTO        = 3'h7;
    localparam logic        RETRY_NVM_DEFAULT = 1'b0;
    localparam int          CML_IVD_BIT       = 6;
    localparam longint      CLK_HZ            = 125000000;
    localparam longint      RESTART_MS        = 52;
    localparam longint      RESTART_CYCLES    = (CLK_HZ / 1000) * RESTART_MS;
    localparam int          CNT_W             = 23;
    typedef enum logic [2:0]
    {
        OTF_RUN      = 3'h1,
        OTF_LATCHED  = 3'h2,
        OTF_WAITING  = 3'h4
    } otflr_state_t;
endpackage

/* File: hw/otflr_nvm.sv */
// Small nonvolatile image of the threshold and retry settings
`timescale 1ns/1ps
module otflr_nvm
(
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       store,
    input  wire logic [5:0] store_mant,
    input  wire logic       store_retry,
    output logic      [5:0] load_mant,
    output logic            load_retry
);
    logic [5:0] mant_q  = otflr_pkg::THR_MANT_DEFAULT;
    logic [5:0] mant_d;
    logic       retry_q = otflr_pkg::RETRY_NVM_DEFAULT;
    logic       retry_d;
    always_comb
    begin
        mant_d  = (store && resetn) ? store_mant : mant_q;
        retry_d = (store && resetn) ? store_retry : retry_q;
    end
    // Image survives reset; only a store changes it
    always_ff @(posedge ref_clk)
    begin
        mant_q  <= mant_d;
        retry_q <= retry_d;
    end
    assign load_mant  = mant_q;
    assign load_retry = retry_q;
endmodule

/* File: hw/otflr_bin.sv */
// Bins a threshold mantissa to the applied temperature and its canonical code
`timescale 1ns/1ps
module otflr_bin
(
    input  wire logic [5:0] mant,
    output logic      [7:0] temp_c,
    output logic      [5:0] canon
);
    always_comb
    begin
        if (mant < 6'h1E)
        begin
            temp_c = 8'h73;
            canon  = 6'h1D;
        end
        else if (mant == 6'h1E)
        begin
            temp_c = 8'h78;
            canon  = 6'h1E;
        end
        else if (mant == 6'h1F)
        begin
            temp_c = 8'h7D;
            canon  = 6'h1F;
        end
        else if (mant < 6'h22)
        begin
            temp_c = 8'h82;
            canon  = 6'h20;
        end
        else if (mant == 6'h22)
        begin
            temp_c = 8'h87;
            canon  = 6'h22;
        end
        else if (mant == 6'h23)
        begin
            temp_c = 8'h8C;
            canon  = 6'h23;
        end
        else if (mant == 6'h24)
        begin
            temp_c = 8'h91;
            canon  = 6'h24;
        end
        else
        begin
            temp_c = 8'h96;
            canon  = 6'h25;
        end
    end
endmodule

/* File: hw/otflr_top.sv */
// Overtemperature fault threshold, response configuration and fault control
`timescale 1ns/1ps
module otflr_top
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        wr_req,
    input  wire logic        wr_word,
    input  wire logic [7:0]  wr_cmd,
    input  wire logic [15:0] wr_data,
    input  wire logic        rd_req,
    input  wire logic [7:0]  rd_cmd,
    input  wire logic        nvm_store,
    input  wire logic        enable,
    input  wire logic        clear_faults,
    input  wire logic [7:0]  die_temp_c,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    output logic             wr_ack,
    output logic             wr_nack,
    output logic             output_enable,
    output logic             overtemp_fault_flag,
    output logic             cml_flag,
    output logic             ivd_flag,
    output logic             host_alert_line
);
    // ------------------------------------------------------------
    // Settings storage and restore
    // ------------------------------------------------------------
    logic [5:0]  nvm_mant;
    logic        nvm_retry;
    logic [5:0]  nvm_canon;
    logic [5:0]  mant_q;
    logic [5:0]  mant_d;
    logic [2:0]  retry_q;
    logic [2:0]  retry_d;
    logic        loaded_q;
    logic        loaded_d;
    logic [7:0]  applied_temp;
    otflr_nvm u_nvm
    (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .store       (nvm_store),
        .store_mant  (mant_q),
        .store_retry (retry_q[2]),
        .load_mant   (nvm_mant),
        .load_retry  (nvm_retry)
    );
    otflr_bin u_restore_bin
    (
        .mant   (nvm_mant),
        .temp_c (),
        .canon  (nvm_canon)
    );
    otflr_bin u_applied_bin
    (
        .mant   (mant_q),
        .temp_c (applied_temp),
        .canon  ()
    );
    // ------------------------------------------------------------
    // Write decoding
    // ------------------------------------------------------------
    function automatic logic [7:0] rsp_byte(input logic [2:0] r);
        rsp_byte = {1'b1, 1'b0, r, r};
    endfunction
    function automatic logic [15:0] thr_word(input logic [5:0] m);
        thr_word = {otflr_pkg::THR_EXPONENT, 5'h00, m};
    endfunction
    logic        wr_thr;
    logic        wr_rsp;
    logic        thr_bad;
    logic        rsp_bad;
    logic        wr_bad;
    logic        wr_good;
    always_comb
    begin
        wr_thr  = wr_req && wr_word && (wr_cmd == otflr_pkg::CMD_OT_THRESHOLD);
        wr_rsp  = wr_req && !wr_word && (wr_cmd == otflr_pkg::CMD_OT_RESPONSE);
        thr_bad = wr_data[otflr_pkg::THR_EXP_MSB:otflr_pkg::THR_RSV_LSB]
                  != {otflr_pkg::THR_EXPONENT, 5'h00};
        rsp_bad = (wr_data[7:0] != rsp_byte(wr_data[otflr_pkg::RSP_RETRY_MSB:otflr_pkg::RSP_RETRY_LSB]))
                  || (wr_data[otflr_pkg::RSP_RETRY_MSB:otflr_pkg::RSP_RETRY_LSB] != otflr_pkg::RETRY_LATCH
                  && wr_data[otflr_pkg::RSP_RETRY_MSB:otflr_pkg::RSP_RETRY_LSB] != otflr_pkg::RETRY_AUTO);
        wr_bad  = (wr_thr && thr_bad) || (wr_rsp && rsp_bad);
        wr_good = (wr_thr && !thr_bad) || (wr_rsp && !rsp_bad);
    end
    always_comb
    begin
        mant_d   = mant_q;
        retry_d  = retry_q;
        loaded_d = 1'b1;
        if (!loaded_q)
        begin
            mant_d  = nvm_canon;
            retry_d = {3{nvm_retry}};
        end
        else if (wr_thr && !thr_bad)
            mant_d = wr_data[otflr_pkg::THR_MANT_MSB:0];
        else if (wr_rsp && !rsp_bad)
            retry_d = wr_data[otflr_pkg::RSP_RETRY_MSB:otflr_pkg::RSP_RETRY_LSB];
    end
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            mant_q   <= otflr_pkg::THR_MANT_DEFAULT;
            retry_q  <= otflr_pkg::RETRY_LATCH;
            loaded_q <= 1'b0;
        end
        else
        begin
            mant_q   <= mant_d;
            retry_q  <= retry_d;
            loaded_q <= loaded_d;
        end
    end
    // ------------------------------------------------------------
    // Bus answers and status flags
    // ------------------------------------------------------------
    logic [15:0] rd_data_d;
    logic        rd_valid_d;
    logic        wr_ack_d;
    logic        wr_nack_d;
    logic        cml_d;
    logic        ivd_d;
    always_comb
    begin
        rd_valid_d = rd_req;
        rd_data_d  = 16'h0000;
        if (rd_cmd == otflr_pkg::CMD_OT_THRESHOLD)
            rd_data_d = thr_word(mant_q);
        else if (rd_cmd == otflr_pkg::CMD_OT_RESPONSE)
            rd_data_d = {8'h00, rsp_byte(retry_q)};
        else if (rd_cmd == otflr_pkg::CMD_STATUS_CML)
            rd_data_d = {8'h00, 1'b0, ivd_flag, 6'h00};
        if (!rd_req)
            rd_data_d = rd_data;
        wr_ack_d  = wr_good;
        wr_nack_d = wr_bad || (wr_req && !wr_thr && !wr_rsp);
        cml_d     = wr_bad || (cml_flag && !clear_faults);
        ivd_d     = wr_bad || (ivd_flag && !clear_faults);
    end
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            rd_data  <= 16'h0000;
            rd_valid <= 1'b0;
            wr_ack   <= 1'b0;
            wr_nack  <= 1'b0;
            cml_flag <= 1'b0;
            ivd_flag <= 1'b0;
        end
        else
        begin
            rd_data  <= rd_data_d;
            rd_valid <= rd_valid_d;
            wr_ack   <= wr_ack_d;
            wr_nack  <= wr_nack_d;
            cml_flag <= cml_d;
            ivd_flag <= ivd_d;
        end
    end
    // ------------------------------------------------------------
    // Fault detection and response
    // ------------------------------------------------------------
    otflr_pkg::otflr_state_t state_q;
    otflr_pkg::otflr_state_t state_d;
    logic [otflr_pkg::CNT_W-1:0] cnt_q;
    logic [otflr_pkg::CNT_W-1:0] cnt_d;
    logic        enable_q;
    logic        fault_now;
    logic        oe_d;
    logic        flag_d;
    logic        alert_d;
    always_comb
    begin
        fault_now = loaded_q && (die_temp_c >= applied_temp);
        state_d   = state_q;
        cnt_d     = cnt_q;
        case (state_q)
            otflr_pkg::OTF_RUN:
                if (fault_now && enable)
                begin
                    cnt_d   = '0;
                    state_d = (retry_q == otflr_pkg::RETRY_AUTO) ? otflr_pkg::OTF_WAITING
                                                                 : otflr_pkg::OTF_LATCHED;
                end
            otflr_pkg::OTF_LATCHED:
                if (!enable || (enable && !enable_q))
                    state_d = otflr_pkg::OTF_RUN;
            otflr_pkg::OTF_WAITING:
                if (!enable)
                    state_d = otflr_pkg::OTF_RUN;
                else if (cnt_q == otflr_pkg::CNT_W'(otflr_pkg::RESTART_CYCLES - 1))
                    state_d = otflr_pkg::OTF_RUN;
                else
                    cnt_d = cnt_q + 1'b1;
            default:
                state_d = otflr_pkg::OTF_RUN;
        endcase
        oe_d    = enable && (state_d == otflr_pkg::OTF_RUN) && !(fault_now && state_q == otflr_pkg::OTF_RUN);
        flag_d  = (fault_now && enable && state_q == otflr_pkg::OTF_RUN)
                  || (overtemp_fault_flag && !clear_faults);
        alert_d = flag_d || cml_d;
    end
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            state_q             <= otflr_pkg::OTF_RUN;
            cnt_q               <= '0;
            enable_q            <= 1'b0;
            output_enable       <= 1'b0;
            overtemp_fault_flag <= 1'b0;
            host_alert_line     <= 1'b0;
        end
        else
        begin
            state_q             <= state_d;
            cnt_q               <= cnt_d;
            enable_q            <= enable;
            output_enable       <= oe_d;
            overtemp_fault_flag <= flag_d;
            host_alert_line     <= alert_d;
        end
    end
endmodule

/* File: verification/otflr_host.sv */
// Management bus host model driving the command interface
`timescale 1ns/1ps
module otflr_host
(
    input  wire logic        ref_clk,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid,
    input  wire logic        wr_ack,
    input  wire logic        wr_nack,
    output logic             wr_req = 1'b0,
    output logic             wr_word = 1'b0,
    output logic      [7:0]  wr_cmd = 8'h00,
    output logic      [15:0] wr_data = 16'h0000,
    output logic             rd_req = 1'b0,
    output logic      [7:0]  rd_cmd = 8'h00
);
    // ------------------------------
    // Transactions
    // ------------------------------
    task automatic write(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        #1;
        wr_req = 1'b1;
        wr_word = w;
        wr_cmd = c;
        wr_data = d;
        @(posedge ref_clk);
        #1;
        r = {wr_ack, wr_nack};
        wr_req = 1'b0;
        wr_cmd = ~c;
        wr_data = ~d;
    endtask

    task automatic read(input logic [7:0] c, output logic [16:0] r);
        @(posedge ref_clk);
        #1;
        rd_req = 1'b1;
        rd_cmd = c;
        @(posedge ref_clk);
        #1;
        r = {rd_valid, rd_data};
        rd_req = 1'b0;
        rd_cmd = ~c;
    endtask
endmodule

/* File: verification/otflr_monitor.sv */
// Port checker for the overtemperature block
`timescale 1ns/1ps
module otflr_monitor
(
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        wr_req,
    input wire logic        wr_word,
    input wire logic [7:0]  wr_cmd,
    input wire logic [15:0] wr_data,
    input wire logic        rd_req,
    input wire logic [7:0]  rd_cmd,
    input wire logic        nvm_store,
    input wire logic        enable,
    input wire logic        clear_faults,
    input wire logic [7:0]  die_temp_c,
    input wire logic [15:0] rd_data,
    input wire logic        rd_valid,
    input wire logic        wr_ack,
    input wire logic        wr_nack,
    input wire logic        output_enable,
    input wire logic        overtemp_fault_flag,
    input wire logic        cml_flag,
    input wire logic        ivd_flag,
    input wire logic        host_alert_line
);
    // ------------------------------
    // Assertions
    // ------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_write_answer_once: assert property (wr_req |=> (wr_ack ^ wr_nack))
        else $error("write without single answer");
    a_read_valid_next: assert property (rd_req |=> rd_valid)
        else $error("read without valid");
    a_thr_fixed_bits: assert property ($past(rd_req) && $past(rd_cmd) == 8'h4F |-> rd_data[15:6] == 10'h040)
        else $error("threshold fixed bits wrong");
    a_rsp_fixed_bits: assert property ($past(rd_req) && $past(rd_cmd) == 8'h50 |->
        rd_data[15:6] == 10'h002 && rd_data[2:0] == rd_data[5:3])
        else $error("response fixed bits wrong");
    a_retry_code_legal: assert property ($past(rd_req) && $past(rd_cmd) == 8'h50 |-> rd_data[5:3] inside {3'h0, 3'h7})
        else $error("retry field illegal");
    a_ro_write_refused: assert property ($past(wr_req && wr_word && wr_cmd == 8'h4F && wr_data[15:6] != 10'h040) |->
        wr_nack ##1 (ivd_flag && cml_flag))
        else $error("read-only write not refused");
    a_ivd_with_cml: assert property ($rose(ivd_flag) |-> cml_flag)
        else $error("ivd without cml");
    a_ivd_sticky: assert property (ivd_flag && !clear_faults |=> ivd_flag)
        else $error("ivd dropped");
    a_hot_shutdown: assert property (enable && output_enable && die_temp_c >= 8'h96 |=>
        !output_enable && overtemp_fault_flag)
        else $error("no shutdown at top threshold");
    a_alert_on_fault: assert property ($rose(overtemp_fault_flag) |-> ##[0:1] host_alert_line)
        else $error("fault without alert");

    c_fault: cover property ($rose(overtemp_fault_flag));
    c_nack_ivd: cover property (wr_nack ##1 ivd_flag);
    c_restart: cover property ($rose(output_enable));
endmodule

bind otflr_top otflr_monitor i_mon
(
    .ref_clk(ref_clk), .resetn(resetn), .wr_req(wr_req), .wr_word(wr_word), .wr_cmd(wr_cmd),
    .wr_data(wr_data), .rd_req(rd_req), .rd_cmd(rd_cmd), .nvm_store(nvm_store), .enable(enable),
    .clear_faults(clear_faults), .die_temp_c(die_temp_c), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_ack(wr_ack), .wr_nack(wr_nack), .output_enable(output_enable), .overtemp_fault_flag(overtemp_fault_flag),
    .cml_flag(cml_flag), .ivd_flag(ivd_flag), .host_alert_line(host_alert_line)
);

/* File: verification/tb_top.sv */
// Testbench of the overtemperature block
`timescale 1ns/1ps
module tb_top;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        nvm_store = 1'b0;
    logic        enable = 1'b1;
    logic        clear_faults = 1'b0;
    logic [7:0]  die_temp_c = 8'h14;
    logic        wr_req, wr_word, rd_req, rd_valid, wr_ack, wr_nack;
    logic [7:0]  wr_cmd, rd_cmd;
    logic [15:0] wr_data, rd_data;
    logic        output_enable, overtemp_fault_flag, cml_flag, ivd_flag, host_alert_line;
    int          failures = 0;
    int          checks = 0;
    logic [5:0]  mt [8] = '{6'h1D, 6'h1E, 6'h1F, 6'h21, 6'h22, 6'h23, 6'h24, 6'h3F};

    always #4 ref_clk = ~ref_clk;

    otflr_host i_host (.ref_clk(ref_clk), .rd_data(rd_data), .rd_valid(rd_valid), .wr_ack(wr_ack),
        .wr_nack(wr_nack), .wr_req(wr_req), .wr_word(wr_word), .wr_cmd(wr_cmd), .wr_data(wr_data),
        .rd_req(rd_req), .rd_cmd(rd_cmd));
    otflr_top i_dut (.ref_clk(ref_clk), .resetn(resetn), .wr_req(wr_req), .wr_word(wr_word), .wr_cmd(wr_cmd),
        .wr_data(wr_data), .rd_req(rd_req), .rd_cmd(rd_cmd), .nvm_store(nvm_store), .enable(enable),
        .clear_faults(clear_faults), .die_temp_c(die_temp_c), .rd_data(rd_data), .rd_valid(rd_valid),
        .wr_ack(wr_ack), .wr_nack(wr_nack), .output_enable(output_enable),
        .overtemp_fault_flag(overtemp_fault_flag), .cml_flag(cml_flag), .ivd_flag(ivd_flag),
        .host_alert_line(host_alert_line));

    // ------------------------------
    // Helpers
    // ------------------------------
    task automatic close_out;
        if (failures == 0 && checks > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic do_reset;
        resetn = 1'b0;
        step(12);
        resetn = 1'b1;
        step(2);
    endtask

    task automatic wr(input logic w, input logic [7:0] c, input logic [15:0] d, input logic acc);
        logic [1:0] r;
        i_host.write(w, c, d, r);
        chk(16'(r), acc ? 16'h0002 : 16'h0001);
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        logic [16:0] r;
        i_host.read(c, r);
        chk(16'(r[16]), 16'h0001);
        chk(r[15:0], exp);
    endtask

    task automatic wait_oe;
        int n;
        n = 0;
        while (output_enable !== 1'b1 && n < 20)
        begin
            step(1);
            n++;
        end
        chk(16'(output_enable), 16'h0001);
        if (output_enable !== 1'b1)
            close_out();
    endtask

    task automatic recover;
        die_temp_c = 8'h14;
        clear_faults = 1'b1;
        step(1);
        chk(16'(output_enable), 16'h0000);
        clear_faults = 1'b0;
        enable = 1'b0;
        step(1);
        enable = 1'b1;
        wait_oe();
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_defaults;
        rd(8'h4F, 16'h1022);
        rd(8'h50, 16'h0080);
    endtask

    task automatic t_bins;
        int i;
        for (i = 0; i < 8; i++)
        begin
            wr(1'b1, 8'h4F, {10'h040, mt[i]}, 1'b1);
            rd(8'h4F, {10'h040, mt[i]});
            die_temp_c = 8'h72 + 8'(5 * i);
            step(3);
            chk(16'(output_enable), 16'h0001);
            die_temp_c = 8'h73 + 8'(5 * i);
            step(2);
            chk(16'(output_enable), 16'h0000);
            chk(16'({overtemp_fault_flag, host_alert_line}), 16'h0003);
            step(40);
            chk(16'(output_enable), 16'h0000);
            recover();
        end
    endtask

    task automatic t_refuse;
        logic [16:0] r;
        wr(1'b1, 8'h4F, 16'h1824, 1'b0);
        chk(16'({cml_flag, ivd_flag}), 16'h0003);
        rd(8'h4F, 16'h103F);
        i_host.read(8'h7E, r);
        chk(16'(r[6]), 16'h0001);
        clear_faults = 1'b1;
        step(1);
        clear_faults = 1'b0;
        step(1);
        chk(16'(ivd_flag), 16'h0000);
        wr(1'b0, 8'h4F, 16'h0024, 1'b0);
        wr(1'b1, 8'h50, 16'h00BF, 1'b0);
        wr(1'b0, 8'h51, 16'h0000, 1'b0);
        rd(8'h51, 16'h0000);
        wr(1'b0, 8'h50, 16'h00A5, 1'b0);
        wr(1'b0, 8'h50, 16'h00B8, 1'b0);
        wr(1'b0, 8'h50, 16'h003F, 1'b0);
        wr(1'b0, 8'h50, 16'h00FF, 1'b0);
        wr(1'b0, 8'h50, 16'h00BF, 1'b1);
        rd(8'h50, 16'h00BF);
    endtask

    task automatic t_auto;
        die_temp_c = 8'h96;
        step(2);
        chk(16'(output_enable), 16'h0000);
        step(1000);
        chk(16'(output_enable), 16'h0000);
        chk(16'({overtemp_fault_flag, host_alert_line}), 16'h0003);
        die_temp_c = 8'h14;
    endtask

    task automatic t_nvm;
        wr(1'b1, 8'h4F, 16'h1021, 1'b1);
        nvm_store = 1'b1;
        step(1);
        nvm_store = 1'b0;
        do_reset();
        chk(16'({cml_flag, ivd_flag, overtemp_fault_flag}), 16'h0000);
        rd(8'h4F, 16'h1020);
        rd(8'h50, 16'h00BF);
        wait_oe();
    endtask

    initial
    begin
        do_reset();
        wait_oe();
        t_defaults();
        t_bins();
        t_refuse();
        t_auto();
        t_nvm();
        close_out();
    end
endmodule
